// ### logic/programmable_logic_cell.sv
// Programmable logic cell: lookup function, configurable register, carry-select adder
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
// Behaviour
// - A sixteen-entry table realises any function of four inputs.
// - Register behaves as D, T, JK or SR element by configuration.
// - Register has data, load data, clock, enable, clear and load/preset controls.
// - Asynchronous load always takes the fourth data input; this cell loads it on the rising clock edge.
// - Combinational lookup result reaches the outputs bypassing the register.
// - Three outputs, each picking lookup result or register value independently.
// - Packing option feeds the register output back into the lookup.
// - Lookup-chain and register-chain outputs feed the next cell.
// - Subtract inverts B and forces the initial carry to one.
// - Add/subtract select drives the carry only in the chain's first cell.
// - Normal or arithmetic mode steers the eight cell inputs.
// - Cluster controls act in both modes; add/subtract only in arithmetic.
// - Normal mode feeds four inputs; one is carry-in or the fourth input.
// - Carry-in used as lookup input only at a chain's end.
// - Arithmetic mode precomputes sums and carries for carry zero and one.
// - Cluster carry picks a chain; that chain's level picks the sum.
// - Each incoming carry selects its own carry-out; both go forward.
// - Counter enable and up/down from data inputs; sync clear/load cluster-wide.
// - Cluster carry selection points at fifth and tenth cells.
// - Preset is an asynchronous load of one; two clears, one preset; this cell applies clears and preset on the rising clock edge.
// - Clear wins when clear and preset/load are asserted together.
// - Active-low chip-wide clear resets the register above everything.
// - Cluster clock enable, when low, holds the register; clears and preset still act.
module programmable_logic_cell
   import logic_cell_pkg::*;
(
   // Clock and chip-wide clear
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Data inputs
   input  wire logic        baseLutInput,
   input  wire logic        operandAIn,
   input  wire logic        operandBIn,
   input  wire logic        fourthLutInput,
   // Chain inputs
   input  wire logic        carryChainZeroIn,
   input  wire logic        carryChainOneIn,
   input  wire logic        clusterCarryIn,
   input  wire logic        regChainIn,
   // Cluster-wide controls
   input  wire logic        clusterClkEn,
   input  wire logic        clusterClearA,
   input  wire logic        clusterClearB,
   input  wire logic        clusterPresetLoad,
   input  wire logic        clusterSyncClear,
   input  wire logic        clusterSyncLoad,
   input  wire logic        addNotSub,
   // Cell outputs
   output logic             routeOutA,
   output logic             routeOutB,
   output logic             localOut,
   output logic             lutChainOut,
   output logic             regChainOut,
   output logic             carryChainZeroOut,
   output logic             carryChainOneOut,
   output logic             clusterCarryOut
);

   // Configuration state
   logic [15:0]           lutMask_reg;
   logic [CTRL_WIDTH-1:0] ctrl_reg;
   logic                  cellQ_reg;
   logic                  clusterCarryOut_reg;
   bus_state_type         bus_reg;
   logic [31:0]           prdata_reg;
   logic                  pslverr_reg;

   logic                  arithMode;
   reg_kind_type          regKind;
   logic [2:0]            outSel;
   logic                  packFeedback;
   logic                  carryToLut;
   logic                  chainEnd;
   logic                  chainFirst;
   logic                  useRegChain;
   logic                  counterMode;
   logic                  selectPoint;

   assign arithMode    = ctrl_reg[CTRL_ARITH_BIT];
   assign regKind      = reg_kind_type'(ctrl_reg[CTRL_TYPE_MSB:CTRL_TYPE_LSB]);
   assign outSel       = ctrl_reg[CTRL_OUTSEL_MSB:CTRL_OUTSEL_LSB];
   assign packFeedback = ctrl_reg[CTRL_PACK_BIT];
   assign carryToLut   = ctrl_reg[CTRL_CARRYLUT_BIT];
   assign chainEnd     = ctrl_reg[CTRL_CHAINEND_BIT];
   assign chainFirst   = ctrl_reg[CTRL_CHAINFIRST_BIT];
   assign useRegChain  = ctrl_reg[CTRL_REGCHAIN_BIT];
   assign counterMode  = ctrl_reg[CTRL_COUNTER_BIT];
   assign selectPoint  = ctrl_reg[CTRL_SELPOINT_BIT];

   // Carry-select arithmetic
   logic subtract;
   logic operandB;
   logic upCount;
   logic carryZero;
   logic carryOne;
   logic sumZero;
   logic sumOne;
   logic genCarryZero;
   logic genCarryOne;
   logic chainLevel;
   logic arithSum;

   // Counting down reuses the subtract path, so up/down costs no extra logic
   assign upCount   = ~counterMode | fourthLutInput;
   assign subtract  = arithMode & (~addNotSub | ~upCount);
   assign operandB  = operandBIn ^ subtract;
   // Only the chain's first cell sees the select as its carry
   assign carryZero = chainFirst ? subtract : carryChainZeroIn;
   assign carryOne  = chainFirst ? subtract : carryChainOneIn;
   assign sumZero      = operandAIn ^ operandB;
   assign sumOne       = ~(operandAIn ^ operandB);
   assign genCarryZero = operandAIn & operandB;
   assign genCarryOne  = operandAIn | operandB;
   assign chainLevel   = clusterCarryIn ? carryOne : carryZero;
   assign arithSum     = chainLevel ? sumOne : sumZero;

   // Normal-mode lookup
   logic [3:0] lutIndex;
   logic       lutInThree;
   logic       lutResult;
   logic       cellComb;

   // Carry feeds the table only for the cell that closes an adder chain
   assign lutInThree = (carryToLut & chainEnd) ? chainLevel : fourthLutInput;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lut_in
         if (gi == 0) begin : g_in0
            assign lutIndex[gi] = baseLutInput;
         end else if (gi == 1) begin : g_in1
            assign lutIndex[gi] = operandAIn;
         end else if (gi == 2) begin : g_in2
            assign lutIndex[gi] = packFeedback ? cellQ_reg : operandBIn;
         end else begin : g_in3
            assign lutIndex[gi] = lutInThree;
         end
      end
   endgenerate

   assign lutResult = lutMask_reg[lutIndex];
   assign cellComb  = arithMode ? arithSum : lutResult;

   // Register data path
   logic regData;
   logic regNext;
   logic countHold;

   assign regData   = useRegChain ? regChainIn : cellComb;
   assign countHold = arithMode & counterMode & ~baseLutInput;

   always_comb begin
      regNext = cellQ_reg;
      case (regKind)
         REG_D:   regNext = regData;
         REG_T:   regNext = cellQ_reg ^ regData;
         REG_JK:  regNext = (regData & ~cellQ_reg) | (~operandBIn & cellQ_reg);
         REG_SR:  regNext = regData | (~operandBIn & cellQ_reg);
         default: regNext = regData;
      endcase
   end

   // Clears and preset/load act on every edge; clock enable gates sync clear, sync load and the data path
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cellQ_reg <= 1'b0;
      end else if (clusterClearA || clusterClearB) begin
         cellQ_reg <= 1'b0;
      end else if (clusterPresetLoad) begin
         cellQ_reg <= fourthLutInput;
      end else if (clusterClkEn) begin
         if (clusterSyncClear) begin
            cellQ_reg <= 1'b0;
         end else if (clusterSyncLoad) begin
            cellQ_reg <= fourthLutInput;
         end else if (!countHold) begin
            cellQ_reg <= regNext;
         end
      end
   end

   // Carry select point toward the next group of cells
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         clusterCarryOut_reg <= 1'b0;
      end else begin
         clusterCarryOut_reg <= selectPoint & (clusterCarryIn ? carryChainOneOut
                                                              : carryChainZeroOut);
      end
   end

   // Cell outputs; the lookup path stays combinational to keep fabric timing
   assign routeOutA         = outSel[0] ? cellQ_reg : cellComb;
   assign routeOutB         = outSel[1] ? cellQ_reg : cellComb;
   assign localOut          = outSel[2] ? cellQ_reg : cellComb;
   assign lutChainOut       = cellComb;
   assign regChainOut       = cellQ_reg;
   assign carryChainZeroOut = carryZero ? genCarryOne : genCarryZero;
   assign carryChainOneOut  = carryOne ? genCarryOne : genCarryZero;
   assign clusterCarryOut   = clusterCarryOut_reg;

   // APB slave, one wait state
   logic accessPhase;
   logic mapped;
   logic [31:0] readValue;

   assign accessPhase = psel & penable & (bus_reg == BUS_ACK);

   always_comb begin
      mapped    = 1'b1;
      readValue = 32'h0000_0000;
      case (paddr)
         CFG_LUT_OFFSET:  readValue = {16'h0000, lutMask_reg};
         CFG_CTRL_OFFSET: readValue = {{(32-CTRL_WIDTH){1'b0}}, ctrl_reg};
         STATUS_OFFSET:   readValue = {24'h00_0000, clusterCarryOut_reg,
                                       carryChainOneOut, carryChainZeroOut,
                                       lutResult, arithSum, chainLevel,
                                       cellComb, cellQ_reg};
         ID_OFFSET:       readValue = CELL_ID_VALUE;
         default:         mapped = 1'b0;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         bus_reg <= BUS_IDLE;
      end else begin
         case (bus_reg)
            BUS_IDLE: bus_reg <= (psel && penable) ? BUS_ACK : BUS_IDLE;
            BUS_ACK:  bus_reg <= BUS_IDLE;
            default:  bus_reg <= BUS_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (psel && penable && bus_reg == BUS_IDLE) begin
         prdata_reg  <= pwrite ? 32'h0000_0000 : readValue;
         pslverr_reg <= ~mapped;
      end else begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end
   end

   // Configuration writes take effect at the completing edge only
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         lutMask_reg <= LUT_MASK_RESET;
         ctrl_reg    <= CTRL_RESET[CTRL_WIDTH-1:0];
      end else if (accessPhase && pwrite) begin
         if (paddr == CFG_LUT_OFFSET) begin
            lutMask_reg <= pwdata[15:0];
         end
         if (paddr == CFG_CTRL_OFFSET) begin
            ctrl_reg <= pwdata[CTRL_WIDTH-1:0];
         end
      end
   end

   assign pready  = (bus_reg == BUS_ACK);
   assign prdata  = prdata_reg;
   assign pslverr = pslverr_reg;

endmodule // programmable_logic_cell

// ### common/logic_cell_pkg.sv
// Constants shared by the programmable logic cell and its bench
package logic_cell_pkg;
   // APB register byte offsets
   localparam logic [7:0]  CFG_LUT_OFFSET     = 8'h00;
   localparam logic [7:0]  CFG_CTRL_OFFSET    = 8'h04;
   localparam logic [7:0]  STATUS_OFFSET      = 8'h08;
   localparam logic [7:0]  ID_OFFSET          = 8'h0c;

   // Reset values
   localparam logic [15:0] LUT_MASK_RESET     = 16'h0000;
   localparam logic [31:0] CTRL_RESET         = 32'h0000_0000;
   // Arbitrary identification value, names no part
   localparam logic [31:0] CELL_ID_VALUE      = 32'h00c0_ffee;

   // Control register field positions
   localparam int          CTRL_ARITH_BIT     = 0;
   localparam int          CTRL_TYPE_LSB      = 1;
   localparam int          CTRL_TYPE_MSB      = 2;
   localparam int          CTRL_OUTSEL_LSB    = 3;
   localparam int          CTRL_OUTSEL_MSB    = 5;
   localparam int          CTRL_PACK_BIT      = 6;
   localparam int          CTRL_CARRYLUT_BIT  = 7;
   localparam int          CTRL_CHAINEND_BIT  = 8;
   localparam int          CTRL_CHAINFIRST_BIT = 9;
   localparam int          CTRL_REGCHAIN_BIT  = 10;
   localparam int          CTRL_COUNTER_BIT   = 11;
   localparam int          CTRL_SELPOINT_BIT  = 12;
   localparam int          CTRL_WIDTH         = 13;

   // Storage element behaviour
   typedef enum logic [1:0] {
      REG_D  = 2'b00,
      REG_T  = 2'b01,
      REG_JK = 2'b10,
      REG_SR = 2'b11
   } reg_kind_type;

   // Bus slave handshake
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK  = 1'b1
   } bus_state_type;
endpackage

// ### verif/programmable_logic_cell_sva.sv
// Port checker for the programmable logic cell
`timescale 1ns/1ns
module programmable_logic_cell_sva
   import logic_cell_pkg::*;
(
   // Bus
   input wire logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   // Cell inputs
   input wire logic        baseLutInput, operandAIn, operandBIn, fourthLutInput, regChainIn,
   input wire logic        carryChainZeroIn, carryChainOneIn, clusterCarryIn, addNotSub,
   input wire logic        clusterClkEn, clusterClearA, clusterClearB, clusterPresetLoad,
   input wire logic        clusterSyncClear, clusterSyncLoad,
   // Cell outputs
   input wire logic        routeOutA, routeOutB, localOut, lutChainOut, regChainOut,
   input wire logic        carryChainZeroOut, carryChainOneOut, clusterCarryOut
);
   logic [15:0] lut_reg;
   logic [12:0] ctl_reg;
   logic        sub, bE, c0, c1, lvl, noAsync;
   logic [3:0]  idx;
   // Shadow taken at the completing edge, so it never runs ahead of the design
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         lut_reg <= LUT_MASK_RESET;
         ctl_reg <= CTRL_RESET[12:0];
      end else if (psel && penable && pready && pwrite) begin
         if (paddr == CFG_LUT_OFFSET) lut_reg <= pwdata[15:0];
         if (paddr == CFG_CTRL_OFFSET) ctl_reg <= pwdata[12:0];
      end
   end
   always_comb begin
      noAsync = !(clusterClearA | clusterClearB | clusterPresetLoad);
      sub = ctl_reg[0] & (!addNotSub | (ctl_reg[11] & !fourthLutInput));
      bE = operandBIn ^ sub;
      c0 = ctl_reg[9] ? sub : carryChainZeroIn;
      c1 = ctl_reg[9] ? sub : carryChainOneIn;
      lvl = clusterCarryIn ? c1 : c0;
      idx = {ctl_reg[7] & ctl_reg[8] ? lvl : fourthLutInput,
             ctl_reg[6] ? regChainOut : operandBIn, operandAIn, baseLutInput};
   end
   default clocking dc @(posedge mclk); endclocking
   default disable iff (!rst_b);
   lookup_result_a: assert property (!ctl_reg[0] |-> lutChainOut == lut_reg[idx])
      else $error("lookup result wrong");
   arith_sum_a: assert property (ctl_reg[0] |-> lutChainOut == (operandAIn ^ bE ^ lvl))
      else $error("sum wrong");
   carry_pair_a: assert property (ctl_reg[0] |->
      carryChainZeroOut == (c0 ? operandAIn | bE : operandAIn & bE) &&
      carryChainOneOut == (c1 ? operandAIn | bE : operandAIn & bE)) else $error("carry wrong");
   first_sub_a: assert property (ctl_reg[0] && ctl_reg[9] && !ctl_reg[11] && !addNotSub |->
      {carryChainZeroOut, lutChainOut} == {operandAIn | !operandBIn, operandAIn ^ operandBIn})
      else $error("subtract wrong");
   out_select_a: assert property (routeOutA == (ctl_reg[3] ? regChainOut : lutChainOut) &&
      routeOutB == (ctl_reg[4] ? regChainOut : lutChainOut) &&
      localOut == (ctl_reg[5] ? regChainOut : lutChainOut)) else $error("output select wrong");
   clear_wins_a: assert property (clusterClearA || clusterClearB |=> !regChainOut)
      else $error("clear lost");
   preset_load_a: assert property (!clusterClearA && !clusterClearB && clusterPresetLoad |=>
      regChainOut == $past(fourthLutInput)) else $error("async load wrong");
   enable_hold_a: assert property (noAsync && !clusterClkEn |=> $stable(regChainOut))
      else $error("register moved while disabled");
   sync_clear_a: assert property (noAsync && clusterClkEn && clusterSyncClear |=> !regChainOut)
      else $error("sync clear lost");
   reg_chain_a: assert property (noAsync && clusterClkEn && !clusterSyncClear && !clusterSyncLoad
      && ctl_reg[10] && ctl_reg[2:0] == 3'b000 |=> regChainOut == $past(regChainIn))
      else $error("chain shift wrong");
   toggle_kind_a: assert property (noAsync && clusterClkEn && !clusterSyncClear && !clusterSyncLoad
      && !ctl_reg[10] && ctl_reg[2:0] == 3'b010 |=> regChainOut == ($past(regChainOut) ^ $past(lutChainOut)))
      else $error("toggle wrong");
   select_point_a: assert property (clusterCarryOut ==
      $past(ctl_reg[12] & (clusterCarryIn ? carryChainOneOut : carryChainZeroOut)))
      else $error("select point carry wrong");
   sub_cov: cover property (ctl_reg[0] && ctl_reg[9] && !addNotSub);
   clear_preset_cov: cover property (clusterClearA && clusterPresetLoad);
   chain_shift_cov: cover property (ctl_reg[10] && clusterClkEn);
endmodule // programmable_logic_cell_sva

bind programmable_logic_cell programmable_logic_cell_sva chk_u (.*);

// ### verif/cell_neighbour_model.sv
// Previous cell in the cluster: its register and its two carries
`timescale 1ns/1ns
module cell_neighbour_model (
   // Clock, enable and the neighbour's own operands
   input  wire logic mclk, rst_b, clusterClkEn, prevA, prevB, carrySel, shiftIn,
   // Chain outputs toward the cell under test
   output logic      carryChainZeroIn, carryChainOneIn, clusterCarryIn, regChainIn
);
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) regChainIn <= 1'b0;
      else if (clusterClkEn) regChainIn <= shiftIn;
   end
   // Carry out of a bit computed for an assumed carry of 0 and of 1
   assign carryChainZeroIn = prevA & prevB;
   assign carryChainOneIn = prevA | prevB;
   assign clusterCarryIn = carrySel;
endmodule // cell_neighbour_model

// ### verif/programmable_logic_cell_tb_top.sv
// Self-checking bench for the programmable logic cell
`timescale 1ns/1ns
module programmable_logic_cell_tb_top;
   import logic_cell_pkg::*;
   logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        baseLutInput, operandAIn, operandBIn, fourthLutInput, regChainIn, addNotSub;
   logic        carryChainZeroIn, carryChainOneIn, clusterCarryIn, prevA, prevB, carrySel;
   logic        clusterClkEn, clusterClearA, clusterClearB, clusterPresetLoad, shiftIn;
   logic        clusterSyncClear, clusterSyncLoad, routeOutA, routeOutB, localOut;
   logic        lutChainOut, regChainOut, carryChainZeroOut, carryChainOneOut, clusterCarryOut;
   logic        expQ, sub, bE, c0, c1, lvl;
   int          n_mismatch = 0;
   int          checked = 0;
   // Steps {data, controls} for the priority test, and the register value each of the first nine leaves
   localparam logic [9:0] STEPS [10] = '{10'h204, 10'h214, 10'h204, 10'h008, 10'h060,
                                         10'h000, 10'h063, 10'h260, 10'h044, 10'h000};
   localparam logic [8:0]  STEP_Q  = 9'h0b5;
   localparam logic [15:0] MASK_A  = 16'hb4e1;
   localparam logic [9:0]  SHIFT_P = 10'h24d;

   programmable_logic_cell dut_u (.*);
   cell_neighbour_model nbr_u (.*);

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic stop_test;
      if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Slave answer time is not assumed; only the watchdog ends a wait
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // d: {fourth, B, A, base}; c: {clkEn, clearA, clearB, preset, syncClear, syncLoad}
   task automatic drive(input logic [3:0] d, input logic [5:0] c, input logic [4:0] n);
      @(posedge mclk);
      {fourthLutInput, operandBIn, operandAIn, baseLutInput} <= d;
      {clusterClkEn, clusterClearA, clusterClearB, clusterPresetLoad} <= c[5:2];
      {clusterSyncClear, clusterSyncLoad} <= c[1:0];
      {prevA, prevB, carrySel, shiftIn, addNotSub} <= n;
      #1;
   endtask

   function automatic logic nextQ(input int k, input logic q, input logic d, input logic r);
      case (k)
         0: return d;
         1: return q ^ d;
         2: return (d & !q) | (!r & q);
         default: return d | (q & !r);
      endcase
   endfunction

   initial begin
      {psel, penable, pwrite, paddr, pwdata, rst_b} = '0;
      {baseLutInput, operandAIn, operandBIn, fourthLutInput, clusterClkEn, clusterClearA} = '0;
      {clusterClearB, clusterPresetLoad, clusterSyncClear, clusterSyncLoad} = '0;
      {prevA, prevB, carrySel, shiftIn, addNotSub} = '0;
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      apb(1'b1, ID_OFFSET, 32'h0);
      apb(1'b0, ID_OFFSET, 32'h0);
      chk(rd, CELL_ID_VALUE);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, CFG_LUT_OFFSET, {16'h0, MASK_A});
      for (int i = 0; i < 16; i++) begin
         drive(i[3:0], 6'h00, {4'h0, i[0]});
         chk({routeOutA, routeOutB, localOut, lutChainOut}, {4{MASK_A[i]}});
      end
      for (int e = 0; e < 2; e++) begin
         apb(1'b1, CFG_CTRL_OFFSET, 32'h80 | (e << 8));
         drive(4'h0, 6'h00, 5'h15);
         chk(lutChainOut, MASK_A[8 * e]);
      end
      apb(1'b1, CFG_LUT_OFFSET, 32'haaaa);
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, CFG_CTRL_OFFSET, 32'h28 | (k << 1));
         drive(4'h0, 6'h10, 5'h01);
         expQ = 1'b0;
         for (int j = 0; j < 8; j++) begin
            drive({1'b0, j[1], 1'b0, j[0]}, 6'h20, 5'h01);
            chk({regChainOut, routeOutA, localOut, routeOutB}, {{3{expQ}}, j[0]});
            expQ = nextQ(k, expQ, j[0], j[1]);
         end
      end
      apb(1'b1, CFG_CTRL_OFFSET, 32'h28);
      for (int s = 0; s < 10; s++) begin
         drive(STEPS[s][9:6], STEPS[s][5:0], 5'h01);
         if (s > 0) chk(regChainOut, STEP_Q[s - 1]);
      end
      drive(4'h8, 6'h21, 5'h01);
      drive(4'h0, 6'h00, 5'h01);
      chk(regChainOut, 1'b1);
      apb(1'b1, CFG_CTRL_OFFSET, 32'h428);
      for (int j = 0; j < 10; j++) begin
         drive(4'h0, 6'h20, {3'h0, SHIFT_P[j], 1'b1});
         if (j > 1) chk({regChainOut, lutChainOut}, {SHIFT_P[j - 2], 1'b0});
      end
      apb(1'b1, CFG_LUT_OFFSET, 32'hf0f0);
      apb(1'b1, CFG_CTRL_OFFSET, 32'h68);
      for (int v = 0; v < 2; v++) begin
         drive(4'h8, v ? 6'h04 : 6'h10, 5'h01);
         drive(4'h0, 6'h00, 5'h01);
         chk(lutChainOut, v);
      end
      for (int f = 0; f < 2; f++) begin
         apb(1'b1, CFG_CTRL_OFFSET, 32'h1 | (f << 9));
         for (int i = 0; i < 64; i++) begin
            drive({1'b1, i[1], i[0], 1'b0}, 6'h00, {i[3], i[4], i[5], 1'b0, i[2]});
            sub = !i[2];
            bE = i[1] ^ sub;
            c0 = f ? sub : i[3] & i[4];
            c1 = f ? sub : i[3] | i[4];
            lvl = i[5] ? c1 : c0;
            chk({lutChainOut, routeOutA, carryChainZeroOut, carryChainOneOut},
                {{2{i[0] ^ bE ^ lvl}}, c0 ? i[0] | bE : i[0] & bE, c1 ? i[0] | bE : i[0] & bE});
         end
      end
      // Counter: base input enables, fourth input picks up (1) or down (0)
      apb(1'b1, CFG_CTRL_OFFSET, 32'ha01);
      drive(4'h2, 6'h10, 5'h01);
      chk(carryChainZeroOut, 1'b1);
      drive(4'h2, 6'h20, 5'h01);
      drive(4'hb, 6'h20, 5'h01);
      chk({regChainOut, carryChainZeroOut}, 2'b00);
      drive(4'hb, 6'h20, 5'h01);
      chk(regChainOut, 1'b1);
      apb(1'b1, CFG_CTRL_OFFSET, 32'h1001);
      for (int s = 0; s < 3; s++) begin
         if (s == 2) apb(1'b1, CFG_CTRL_OFFSET, 32'h1);
         drive(4'h3, 6'h00, {2'b01, s != 0, 2'b01});
         drive(4'h3, 6'h00, {2'b01, s != 0, 2'b01});
         chk(clusterCarryOut, s == 1);
      end
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk(rd, 32'h45);
      // Chip-wide clear in mid-run overrides a held preset
      drive(4'h8, 6'h04, 5'h01);
      drive(4'h8, 6'h04, 5'h01);
      @(posedge mclk);
      rst_b <= 1'b0;
      #1 chk(regChainOut, 1'b0);
      // Preset still held at this edge; inputs go idle before release
      drive(4'h0, 6'h00, 5'h01);
      chk(regChainOut, 1'b0);
      @(posedge mclk);
      rst_b <= 1'b1;
      drive(4'h0, 6'h00, 5'h01);
      apb(1'b0, CFG_CTRL_OFFSET, 32'h0);
      chk(rd, CTRL_RESET);
      stop_test();
   end

   initial begin
      #200000;
      n_mismatch++;
      stop_test();
   end
endmodule // programmable_logic_cell_tb_top
